// ===== core/mrc_pkg.sv
package mrc_pkg;

   // Register byte offsets on the bus
   localparam logic [3:0]  REG_MODE_VIEW   = 4'h0;
   localparam logic [3:0]  REG_SYS_CTRL    = 4'h4;
   localparam logic [3:0]  REG_IRQ_ENABLE  = 4'h8;
   localparam logic [3:0]  REG_STATUS      = 4'hc;

   // Mode view: fixed upper bits 7..2 read 1,1,1,0,0,1
   localparam logic [7:0]  MODE_VIEW_FIXED = 8'he4;

   // System control fields
   localparam int          SYS_RAM_EN_BIT  = 0;
   localparam int          SYS_PIN_RST_BIT = 3;
   localparam logic        RAM_EN_RESET    = 1'b1;
   localparam logic        PIN_RST_RESET   = 1'b1;
   localparam logic [7:0]  IRQ_EN_RESET    = 8'h00;

   // Reset vector location and watchdog reset pulse length
   localparam logic [15:0] VEC_RESET_ADDR  = 16'h0000;
   localparam int          WDT_PULSE_CYCLES = 518;

   // Operating modes, decoded from the two strap levels
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_EXP_NOROM,
      MODE_EXP_ROM,
      MODE_SINGLE
   } mrc_mode_t;

   function automatic mrc_mode_t mrc_decode_mode(input logic hi, input logic lo);
      case ({hi, lo})
         2'b01:   mrc_decode_mode = MODE_EXP_NOROM;
         2'b10:   mrc_decode_mode = MODE_EXP_ROM;
         2'b11:   mrc_decode_mode = MODE_SINGLE;
         default: mrc_decode_mode = MODE_NONE;
      endcase
   endfunction : mrc_decode_mode

endpackage : mrc_pkg

// ===== core/mrc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstB,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   // Two flops; only the second stage is read outside
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule : mrc_sync2

`default_nettype wire

// ===== core/mrc_reset_pulse.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_reset_pulse #(
   parameter int PULSE_CYCLES = mrc_pkg::WDT_PULSE_CYCLES
) (
   input  wire logic clk,
   input  wire logic rstB,
   input  wire logic trigger,
   output logic      active
);

   localparam int CW = $clog2(PULSE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

   logic [CW-1:0] count;

   // Fixed-length pulse; a trigger during the pulse does not stretch it
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         active <= 1'b0;
         count  <= '0;
      end else if (!active && trigger) begin
         active <= 1'b1;
         count  <= '0;
      end else if (active) begin
         count  <= count + 1'b1;
         if (count == LAST) begin
            active <= 1'b0;
         end
      end
   end

   chk_pulse_len: assert property (@(posedge clk) disable iff (!rstB)
      $fell(active) |-> $past(count) == LAST)
      else $error("watchdog reset pulse length wrong");

endmodule : mrc_reset_pulse

`default_nettype wire

// ===== core/mrc_mode_reset_ctrl.sv
// Behaviour
// - Mode view reads 1,1,1 in bits 7..5, 0,0 in 4..3, 1 in bit 2; unwritable.
// - Mode view bits 1 and 0 show upper and lower strap pins; read-only.
// - Each read of the mode view latches both strap levels into bits 1..0.
// - Mode taken from straps as reset ends: 01 exp no ROM, 10 exp ROM, 11 single.
// - Expanded without ROM: 64 kbyte external space, external vectors, ROM off, RAM optional.
// - Expanded without ROM: ports 1,2 address, port 3 data, port 7 bus control.
// - Expanded with ROM: ROM on, ports 1,2 start as inputs until software changes.
// - Single-chip: internal memory only, no external bus, all ports general purpose.
// - Only reset and interrupt exceptions; reset always beats any interrupt.
// - Reset pin low enters reset at once; sequence starts when pin rises. Here both lag the pin by the two-flop synchroniser.
// - Interrupts taken only at instruction or exception sequence end.
// - No interrupt after the four flag manipulation instructions.
// - Watchdog reset stops processing and initialises CPU and module registers.
// - Watchdog reset pulse lasts exactly 518 clocks.
// - Reset sequence sets interrupt mask first, then initialises module registers.
// - Sequence ends loading program counter from vector word at address 0.
// - All interrupts, NMI too, blocked until first instruction completes.
// - Maskable sources stay off until their enable bits are set.
// - A flag instruction first keeps everything blocked after it.
// - Pin reset sets the reset-source flag; watchdog reset clears it.
`timescale 1ns/1ps
`default_nettype none

module mrc_mode_reset_ctrl #(
   parameter int IRQ_COUNT = 8
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   // Avalon-MM slave
   input  wire logic [3:0]           avsAddress,
   input  wire logic                 avsRead,
   input  wire logic                 avsWrite,
   input  wire logic [31:0]          avsWriteData,
   input  wire logic [3:0]           avsByteEnable,
   output logic      [31:0]          avsReadData,
   output logic                      avsWaitRequest,
   // Pins
   input  wire logic                 resetInN,
   input  wire logic                 modeStrapHi,
   input  wire logic                 modeStrapLo,
   // Watchdog
   input  wire logic                 wdtOverflow,
   input  wire logic                 wdtResetSel,
   // CPU side
   input  wire logic                 instrDone,
   input  wire logic                 instrIsFlagsOp,
   input  wire logic                 exceptSeqDone,
   input  wire logic                 flagsMaskI,
   input  wire logic                 nmiPending,
   input  wire logic [IRQ_COUNT-1:0] irqReq,
   input  wire logic                 vecValid,
   input  wire logic [15:0]          vecData,
   output logic                      cpuHold,
   output logic                      moduleInitN,
   output logic                      flagsMaskSet,
   output logic                      vecRead,
   output logic      [15:0]          vecAddr,
   output logic                      pcLoad,
   output logic      [15:0]          pcValue,
   output logic                      nmiTake,
   output logic                      irqTake,
   output logic      [$clog2(IRQ_COUNT)-1:0] irqTakeId,
   // Mode-dependent controls
   output logic      [1:0]           modeCode,
   output logic                      romEnable,
   output logic                      vectorsExternal,
   output logic                      ramEnable,
   output logic                      addrPortsBus,
   output logic                      addrPortsGpioInit,
   output logic                      dataPortBus,
   output logic                      busCtrlPort,
   output logic                      allPortsGpio,
   output logic                      modeInvalid
);

   localparam int IW = $clog2(IRQ_COUNT);

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_MASK,
      ST_INIT,
      ST_FETCH,
      ST_FIRST,
      ST_RUN
   } mrc_state_t;

   logic               coreRstB;
   logic [2:0]         pinSync;
   logic               pinRstN;
   logic               strapHi;
   logic               strapLo;
   logic               wdtActive;
   logic               inReset;
   mrc_state_t         state;
   mrc_pkg::mrc_mode_t modeSel;
   logic [1:0]         modeView;
   logic               pinResetFlag;
   logic [IRQ_COUNT-1:0] irqEnable;
   logic               busReq;
   logic               busAck;
   logic               boundary;
   logic [IRQ_COUNT-1:0] irqLive;
   logic [31:0]        next_readData;

   // Lowest pending index wins
   function automatic logic [IW-1:0] first_set(input logic [IRQ_COUNT-1:0] v);
      first_set = '0;
      for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = IW'(i);
         end
      end
   endfunction : first_set

   // Reset release through two flops
   mrc_sync2 #(.WIDTH(1)) uRstSync (
      .clk  (core_clk),
      .rstB (rst_b),
      .din  (1'b1),
      .dout (coreRstB)
   );

   // Pins come from outside the clock domain
   mrc_sync2 #(.WIDTH(3)) uPinSync (
      .clk  (core_clk),
      .rstB (coreRstB),
      .din  ({resetInN, modeStrapHi, modeStrapLo}),
      .dout (pinSync)
   );

   assign pinRstN = pinSync[2];
   assign strapHi = pinSync[1];
   assign strapLo = pinSync[0];

   // Watchdog reset pulse, only when the reset option is chosen
   mrc_reset_pulse #(.PULSE_CYCLES(mrc_pkg::WDT_PULSE_CYCLES)) uWdtPulse (
      .clk     (core_clk),
      .rstB    (coreRstB),
      .trigger (wdtOverflow && wdtResetSel),
      .active  (wdtActive)
   );

   // Either source holds the chip in reset; pin latency is the synchroniser
   assign inReset  = !pinRstN || wdtActive;
   assign boundary = instrDone || exceptSeqDone;
   assign irqLive  = irqReq & irqEnable;

   // Reset sequence; reset overrides every other state
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         state        <= ST_HOLD;
         cpuHold      <= 1'b1;
         moduleInitN  <= 1'b0;
         flagsMaskSet <= 1'b0;
         vecRead      <= 1'b0;
         vecAddr      <= mrc_pkg::VEC_RESET_ADDR;
         pcLoad       <= 1'b0;
         pcValue      <= 16'h0000;
      end else begin
         flagsMaskSet <= 1'b0;
         pcLoad       <= 1'b0;
         moduleInitN  <= 1'b1;
         if (inReset) begin
            state       <= ST_HOLD;
            cpuHold     <= 1'b1;
            moduleInitN <= 1'b0;
            vecRead     <= 1'b0;
         end else begin
            case (state)
               ST_HOLD: begin
                  state        <= ST_MASK;
                  flagsMaskSet <= 1'b1;
               end
               ST_MASK: begin
                  state       <= ST_INIT;
                  moduleInitN <= 1'b0;
               end
               ST_INIT: begin
                  state   <= ST_FETCH;
                  vecRead <= 1'b1;
                  vecAddr <= mrc_pkg::VEC_RESET_ADDR;
               end
               ST_FETCH: begin
                  if (vecValid) begin
                     vecRead <= 1'b0;
                     pcValue <= vecData;
                     pcLoad  <= 1'b1;
                     cpuHold <= 1'b0;
                     state   <= ST_FIRST;
                  end
               end
               ST_FIRST: begin
                  // A flag instruction first keeps the window shut
                  if (instrDone && !instrIsFlagsOp) begin
                     state <= ST_RUN;
                  end
               end
               default: begin
                  state <= ST_RUN;
               end
            endcase
         end
      end
   end

   // Interrupt acceptance at boundaries only, NMI ahead of maskable ones
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         nmiTake   <= 1'b0;
         irqTake   <= 1'b0;
         irqTakeId <= '0;
      end else begin
         nmiTake <= 1'b0;
         irqTake <= 1'b0;
         if (!inReset && state == ST_RUN && boundary
             && !(instrDone && instrIsFlagsOp)) begin
            if (nmiPending) begin
               nmiTake <= 1'b1;
            end else if (|irqLive && !flagsMaskI) begin
               irqTake   <= 1'b1;
               irqTakeId <= first_set(irqLive);
            end
         end
      end
   end

   // Mode captured once as reset ends and held until the next reset
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         modeSel <= mrc_pkg::MODE_NONE;
      end else if (state == ST_HOLD && !inReset) begin
         modeSel <= mrc_pkg::mrc_decode_mode(strapHi, strapLo);
      end
   end

   // Port and memory use follow the held mode
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         modeCode          <= 2'h0;
         romEnable         <= 1'b0;
         vectorsExternal   <= 1'b0;
         addrPortsBus      <= 1'b0;
         addrPortsGpioInit <= 1'b0;
         dataPortBus       <= 1'b0;
         busCtrlPort       <= 1'b0;
         allPortsGpio      <= 1'b0;
         modeInvalid       <= 1'b0;
      end else begin
         modeCode          <= modeSel;
         romEnable         <= modeSel == mrc_pkg::MODE_EXP_ROM
                              || modeSel == mrc_pkg::MODE_SINGLE;
         vectorsExternal   <= modeSel == mrc_pkg::MODE_EXP_NOROM;
         addrPortsBus      <= modeSel == mrc_pkg::MODE_EXP_NOROM;
         addrPortsGpioInit <= modeSel == mrc_pkg::MODE_EXP_ROM;
         dataPortBus       <= modeSel == mrc_pkg::MODE_EXP_NOROM
                              || modeSel == mrc_pkg::MODE_EXP_ROM;
         busCtrlPort       <= modeSel == mrc_pkg::MODE_EXP_NOROM
                              || modeSel == mrc_pkg::MODE_EXP_ROM;
         allPortsGpio      <= modeSel == mrc_pkg::MODE_SINGLE;
         modeInvalid       <= modeSel == mrc_pkg::MODE_NONE;
      end
   end

   // Reset-source flag survives the init sweep; later source wins, watchdog if both are active
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         pinResetFlag <= mrc_pkg::PIN_RST_RESET;
      end else if (wdtActive) begin
         pinResetFlag <= 1'b0;
      end else if (!pinRstN) begin
         pinResetFlag <= 1'b1;
      end
   end

   // Bus handshake: one wait cycle, then a single accept cycle
   assign busReq = (avsRead || avsWrite) && avsWaitRequest;
   assign busAck = (avsRead || avsWrite) && !avsWaitRequest;

   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         avsWaitRequest <= 1'b1;
      end else begin
         avsWaitRequest <= !(busReq);
      end
   end

   // Strap levels latched on each mode view read
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         modeView <= 2'h0;
      end else if (state == ST_HOLD && !inReset) begin
         modeView <= {strapHi, strapLo};
      end else if (busReq && avsRead && avsAddress == mrc_pkg::REG_MODE_VIEW) begin
         modeView <= {strapHi, strapLo};
      end
   end

   // Writable control; restored to its reset values by any reset of the chip
   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         ramEnable <= mrc_pkg::RAM_EN_RESET;
         irqEnable <= IRQ_COUNT'(mrc_pkg::IRQ_EN_RESET);
      end else if (!moduleInitN) begin
         ramEnable <= mrc_pkg::RAM_EN_RESET;
         irqEnable <= IRQ_COUNT'(mrc_pkg::IRQ_EN_RESET);
      end else if (busAck && avsWrite && avsByteEnable[0]) begin
         if (avsAddress == mrc_pkg::REG_SYS_CTRL) begin
            ramEnable <= avsWriteData[mrc_pkg::SYS_RAM_EN_BIT];
         end else if (avsAddress == mrc_pkg::REG_IRQ_ENABLE) begin
            irqEnable <= avsWriteData[IRQ_COUNT-1:0];
         end
      end
   end

   // Read decode; the mode view returns the strap levels being latched
   always_comb begin
      next_readData = 32'h0000_0000;
      if (avsAddress == mrc_pkg::REG_MODE_VIEW) begin
         next_readData[7:0] = mrc_pkg::MODE_VIEW_FIXED | {6'h00, strapHi, strapLo};
      end else if (avsAddress == mrc_pkg::REG_SYS_CTRL) begin
         next_readData[mrc_pkg::SYS_PIN_RST_BIT] = pinResetFlag;
         next_readData[mrc_pkg::SYS_RAM_EN_BIT]  = ramEnable;
      end else if (avsAddress == mrc_pkg::REG_IRQ_ENABLE) begin
         next_readData[IRQ_COUNT-1:0] = irqEnable;
      end else if (avsAddress == mrc_pkg::REG_STATUS) begin
         next_readData[7:0] = {1'b0, state, modeCode, modeView};
      end
   end

   always_ff @(posedge core_clk or negedge coreRstB) begin
      if (!coreRstB) begin
         avsReadData <= 32'h0000_0000;
      end else if (busReq && avsRead) begin
         avsReadData <= next_readData;
      end
   end

   // Checks
   sequence leaveHold;
      state == ST_HOLD && !inReset;
   endsequence

   sequence maskThenInit;
      flagsMaskSet && moduleInitN ##1 !moduleInitN && !flagsMaskSet;
   endsequence

   chk_view_fixed_bits: assert property (@(posedge core_clk) disable iff (!coreRstB)
      busAck && avsRead && avsAddress == mrc_pkg::REG_MODE_VIEW
      |-> avsReadData[7:2] == 6'b111001)
      else $error("mode view fixed bits wrong");

   chk_view_latch: assert property (@(posedge core_clk) disable iff (!coreRstB)
      busReq && avsRead && avsAddress == mrc_pkg::REG_MODE_VIEW
      |=> modeView[1] == $past(strapHi) && modeView[0] == $past(strapLo)
          && avsReadData[1:0] == modeView)
      else $error("mode view did not latch straps");

   chk_reset_wins: assert property (@(posedge core_clk) disable iff (!coreRstB)
      inReset |=> state == ST_HOLD && cpuHold && !nmiTake && !irqTake)
      else $error("reset did not take priority");

   chk_mask_init_order: assert property (@(posedge core_clk) disable iff (!coreRstB)
      leaveHold ##1 !inReset |-> maskThenInit)
      else $error("mask and init out of order");

   chk_pc_vector: assert property (@(posedge core_clk) disable iff (!coreRstB)
      state == ST_FETCH && vecValid && !inReset
      |=> pcLoad && pcValue == $past(vecData) && vecAddr == 16'h0000)
      else $error("program counter not loaded from vector");

   chk_first_block: assert property (@(posedge core_clk) disable iff (!coreRstB)
      state != ST_RUN |=> !nmiTake && !irqTake)
      else $error("interrupt taken before first instruction");

   chk_flags_op_block: assert property (@(posedge core_clk) disable iff (!coreRstB)
      instrDone && instrIsFlagsOp |=> !nmiTake && !irqTake)
      else $error("interrupt after flag instruction");

   chk_irq_enabled: assert property (@(posedge core_clk) disable iff (!coreRstB)
      irqTake |-> $past(irqLive) != '0 && !$past(flagsMaskI))
      else $error("disabled source taken");

   chk_mode_held: assert property (@(posedge core_clk) disable iff (!coreRstB)
      state != ST_HOLD && $past(state) != ST_HOLD |-> $stable(modeSel))
      else $error("mode changed outside reset");

   chk_source_flag: assert property (@(posedge core_clk) disable iff (!coreRstB)
      wdtActive |=> !pinResetFlag)
      else $error("watchdog reset did not clear source flag");

endmodule : mrc_mode_reset_ctrl

`default_nettype wire

// ===== tb/mrc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module mrc_board_model (
   input  wire logic        clk,
   output logic             resetInN,
   output logic             modeStrapHi,
   output logic             modeStrapLo,
   input  wire logic        vecRead,
   input  wire logic [15:0] vecAddr,
   output logic             vecValid,
   output logic      [15:0] vecData
);
   logic [15:0] vec;
   int          lat;
   int          cnt;

   // Pin low and straps at power-up, vector memory idle
   initial begin
      resetInN = 1'b0;
      {modeStrapHi, modeStrapLo} = 2'b10;
      vecValid = 1'b0;
      vecData = 16'h0;
      vec = 16'h1234;
      lat = 0;
      cnt = 0;
   end

   // Board reset: never shorter than the operating minimum of 10 clocks
   task automatic pin_reset(input int n, input logic [1:0] s);
      resetInN <= 1'b0;
      {modeStrapHi, modeStrapLo} <= s;
      repeat ((n < 10) ? 10 : n) @(posedge clk);
      resetInN <= 1'b1;
   endtask : pin_reset

   task automatic set_straps(input logic [1:0] s);
      {modeStrapHi, modeStrapLo} <= s;
   endtask : set_straps

   // Vector memory answers after lat cycles; the data lines churn otherwise
   always @(posedge clk) begin
      if (vecRead && !vecValid && cnt >= lat) begin
         vecValid <= 1'b1;
         vecData  <= (vecAddr == 16'h0) ? vec : ~vec;
         cnt      <= 0;
      end else begin
         vecValid <= 1'b0;
         vecData  <= ~vecData;
         cnt      <= vecRead ? cnt + 1 : 0;
      end
   end
endmodule : mrc_board_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        core_clk, rst_b, avsRead, avsWrite, avsWaitRequest;
   logic [3:0]  avsAddress, avsByteEnable;
   logic [31:0] avsWriteData, avsReadData, rd;
   logic        resetInN, modeStrapHi, modeStrapLo, wdtOverflow, wdtResetSel;
   logic        instrDone, instrIsFlagsOp, exceptSeqDone, flagsMaskI, nmiPending;
   logic [7:0]  irqReq;
   logic        vecValid, cpuHold, moduleInitN, flagsMaskSet, vecRead, pcLoad;
   logic        nmiTake, irqTake, romEnable, vectorsExternal, ramEnable, addrPortsBus;
   logic        addrPortsGpioInit, dataPortBus, busCtrlPort, allPortsGpio, modeInvalid;
   logic [15:0] vecData, vecAddr, pcValue;
   logic [2:0]  irqTakeId;
   logic [1:0]  modeCode;
   int          n_mismatch, n_tests;

   mrc_mode_reset_ctrl dut (.core_clk, .rst_b, .avsAddress, .avsRead, .avsWrite,
      .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .resetInN,
      .modeStrapHi, .modeStrapLo, .wdtOverflow, .wdtResetSel, .instrDone,
      .instrIsFlagsOp, .exceptSeqDone, .flagsMaskI, .nmiPending, .irqReq, .vecValid,
      .vecData, .cpuHold, .moduleInitN, .flagsMaskSet, .vecRead, .vecAddr, .pcLoad,
      .pcValue, .nmiTake, .irqTake, .irqTakeId, .modeCode, .romEnable,
      .vectorsExternal, .ramEnable, .addrPortsBus, .addrPortsGpioInit, .dataPortBus,
      .busCtrlPort, .allPortsGpio, .modeInvalid);

   mrc_board_model brd (.clk(core_clk), .resetInN, .modeStrapHi, .modeStrapLo,
      .vecRead, .vecAddr, .vecValid, .vecData);

   // Free-running 25 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One Avalon access; waits for the answer, only the watchdog ends a hang
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= !w;
      avsWriteData <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (avsWaitRequest !== 1'b0);
      rd = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      // One wait state: the answer is seen on the second edge
      chk("bus wait cycles", 2, k);
   endtask : bus

   // One boundary (instruction or exception sequence end), then the take pulses
   task automatic step(input logic ex, input logic fl, input logic [1:0] e);
      @(posedge core_clk);
      if (ex) exceptSeqDone <= 1'b1;
      else instrDone <= 1'b1;
      instrIsFlagsOp <= fl;
      @(posedge core_clk);
      exceptSeqDone <= 1'b0;
      instrDone <= 1'b0;
      @(posedge core_clk);
      chk("take nmi irq", e, {nmiTake, irqTake});
   endtask : step

   task automatic t_pin_reset(input logic [1:0] s, input logic [15:0] v, input int l);
      int k;
      logic fm, mi, vr;
      logic [7:0] e, g;
      k = 0;
      fm = 0;
      mi = 0;
      vr = 0;
      brd.vec = v;
      brd.lat = l;
      brd.pin_reset(12, s);
      chk("hold in reset", 1, cpuHold);
      while (pcLoad !== 1'b1 && k < 100) begin
         @(posedge core_clk);
         k++;
         if (flagsMaskSet === 1'b1) fm = 1;
         if (moduleInitN === 1'b0 && fm) mi = 1;
         if (vecRead === 1'b1) vr = 1;
         if (vecRead === 1'b1) chk("vector address", 16'h0, vecAddr);
      end
      chk("mask init fetch", 3'b111, {fm, mi, vr});
      chk("pc hold fetch", {v, 2'b00}, {pcValue, cpuHold, vecRead});
      @(posedge core_clk);
      // Rom, ext vectors, address bus, gpio start, data bus, control, all gpio, invalid
      case (s)
         2'b00:   e = 8'b00000001;
         2'b01:   e = 8'b01101100;
         2'b10:   e = 8'b10011100;
         default: e = 8'b10000010;
      endcase
      g = {romEnable, vectorsExternal, addrPortsBus, addrPortsGpioInit, dataPortBus,
           busCtrlPort, allPortsGpio, modeInvalid};
      chk("mode", s, modeCode);
      chk("mode outputs", e, g);
   endtask : t_pin_reset

   // Straps 10 are in force; fixed bits, latching on read, held mode
   task automatic t_regs;
      bus(mrc_pkg::REG_MODE_VIEW, 1, 32'hff);
      bus(mrc_pkg::REG_MODE_VIEW, 0, 0);
      chk("mode view", 32'he6, rd);
      brd.set_straps(2'b01);
      repeat (4) @(posedge core_clk);
      bus(mrc_pkg::REG_MODE_VIEW, 0, 0);
      chk("mode view relatch", 32'he5, rd);
      chk("mode held", 2'b10, modeCode);
      bus(mrc_pkg::REG_SYS_CTRL, 0, 0);
      chk("sys ctrl reset", 2'b11, {rd[3], rd[0]});
      bus(mrc_pkg::REG_SYS_CTRL, 1, 0);
      bus(mrc_pkg::REG_SYS_CTRL, 0, 0);
      chk("sys ctrl write", 2'b10, {rd[3], rd[0]});
      chk("ram enable pin", 0, ramEnable);
      // Byte lane 0 off: the whole write must be dropped
      avsByteEnable <= 4'he;
      bus(mrc_pkg::REG_SYS_CTRL, 1, 32'h9);
      avsByteEnable <= 4'hf;
      bus(mrc_pkg::REG_SYS_CTRL, 0, 0);
      chk("sys ctrl lane", 2'b10, {rd[3], rd[0]});
      bus(mrc_pkg::REG_IRQ_ENABLE, 0, 0);
      chk("irq enable reset", 0, rd[7:0]);
      bus(4'h2, 0, 0);
      chk("unmapped read", 0, rd);
   endtask : t_regs

   // Request 1 and 3 raised, only 2 and 3 enabled: index 3 must win
   task automatic t_irq;
      nmiPending <= 1'b0;
      irqReq <= 8'h0a;
      flagsMaskI <= 1'b1;
      bus(mrc_pkg::REG_IRQ_ENABLE, 1, 32'h0c);
      step(0, 0, 2'b00);
      flagsMaskI <= 1'b0;
      step(0, 1, 2'b00);
      step(0, 0, 2'b01);
      chk("irq id", 3'd3, irqTakeId);
      nmiPending <= 1'b1;
      step(1, 0, 2'b10);
      nmiPending <= 1'b0;
      irqReq <= 8'h00;
   endtask : t_irq

   // Watchdog reset: hold spans the pulse plus the short sequence after it
   task automatic t_wdt;
      int k, n;
      k = 0;
      n = 0;
      brd.lat = 3;
      @(posedge core_clk);
      wdtResetSel <= 1'b1;
      wdtOverflow <= 1'b1;
      @(posedge core_clk);
      wdtOverflow <= 1'b0;
      while (pcLoad !== 1'b1 && k < 700) begin
         @(posedge core_clk);
         k++;
         if (cpuHold === 1'b1) n++;
      end
      chk("watchdog hold", 1, n >= 518 && n <= 535);
      bus(mrc_pkg::REG_SYS_CTRL, 0, 0);
      chk("source after watchdog", 0, rd[3]);
   endtask : t_wdt

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // Main sequence; pending NMI is held over the first reset on purpose
   initial begin
      {rst_b, avsRead, avsWrite, avsAddress, avsWriteData} = '0;
      avsByteEnable = 4'hf;
      {wdtOverflow, wdtResetSel, instrDone, instrIsFlagsOp, exceptSeqDone} = '0;
      {flagsMaskI, irqReq} = '0;
      nmiPending = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_pin_reset(2'b10, 16'h1234, 0);
      step(0, 1, 2'b00);
      step(0, 0, 2'b00);
      step(0, 0, 2'b10);
      nmiPending <= 1'b0;
      t_regs();
      t_irq();
      t_wdt();
      t_pin_reset(2'b11, 16'h8642, 4);
      t_pin_reset(2'b00, 16'h5a5a, 2);
      t_pin_reset(2'b01, 16'h0ace, 1);
      bus(mrc_pkg::REG_SYS_CTRL, 0, 0);
      chk("source after pin", 1, rd[3]);
      tally_and_finish();
   end

   // Whole run needs about 700 cycles; over four times that means a hang
   initial begin
      repeat (3000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire
